// ### rtl/sis_defs.svh
`ifndef SIS_DEFS_SVH
`define SIS_DEFS_SVH

// Host register offsets.
`define SIS_REG_PROC_DIS   12'h000
`define SIS_REG_ANC_BASE   12'h005
`define SIS_REG_ANC_LAST   12'h009
`define SIS_REG_STATUS     12'h01f

// Processing disable register fields and reset value.
`define SIS_DIS_TRS        0
`define SIS_DIS_LINE_NO    1
`define SIS_DIS_LINE_CHK   2
`define SIS_DIS_ANC_SUM    3
`define SIS_DIS_ERR_PKT    4
`define SIS_DIS_BAD_CODE   5
`define SIS_DIS_HCFG       8
`define SIS_DIS_RST        16'h0000
`define SIS_DIS_MASK       16'h013f
`define SIS_ANC_RST        16'h0000
`define SIS_PROC_EN_RST    6'h3f

// Status register fields.
`define SIS_ST_CHOICE      0
`define SIS_ST_MASTER      1
`define SIS_ST_CARRIER_N   2
`define SIS_ST_LOCKED      3
`define SIS_ST_VCO_CTR     4
`define SIS_ST_LOOP_MUTE   5
`define SIS_ST_LOOP_RECLK  6
`define SIS_ST_RATE_LO     8

// Host serial port framing.
`define SIS_HSP_CMD_BITS   6'd16
`define SIS_HSP_FRAME_BITS 6'd32
`define SIS_HSP_RW_BIT     15

// Timing, in nanoseconds and derived clock cycles.
`define SIS_CLK_NS         25
`define SIS_LOCK_QUAL_NS   1000
`define SIS_RATE_DWELL_NS  5000
`define SIS_LOCK_QUAL_CYC  ((`SIS_LOCK_QUAL_NS + `SIS_CLK_NS - 1) / `SIS_CLK_NS)
`define SIS_RATE_DWELL_CYC (`SIS_RATE_DWELL_NS / `SIS_CLK_NS)

`endif

// ### rtl/sis_pkg.sv
package sis_pkg;

    // Line rates the receiver can be centred on.
    typedef enum logic [1:0] {
        SIS_RATE_SD,
        SIS_RATE_HD,
        SIS_RATE_HD_1001
    } sis_rate_t;

    // Lock acquisition states.
    typedef enum logic [1:0] {
        SIS_IDLE,
        SIS_SEEK,
        SIS_LOCKED
    } sis_lock_st_t;

    // Pin inputs that pass the synchroniser together.
    typedef struct packed {
        logic choice;
        logic master;
        logic cd_a_n;
        logic cd_b_n;
        logic ser_a;
        logic ser_b;
        logic pll_lk;
        logic rate_hd;
        logic rate_1001;
        logic reclk_pick;
        logic loop_en;
        logic reclk_data;
    } sis_pins_t;

    // Host serial port state.
    typedef struct packed {
        logic        sclk_prev;
        logic [5:0]  cnt;
        logic [15:0] sh;
        logic [15:0] cmd;
        logic [15:0] tx;
        logic        ld;
        logic        wr;
        logic        sdo;
    } sis_hsp_state_t;

    // Core selection, lock and register state.
    typedef struct packed {
        sis_lock_st_t    st;
        sis_rate_t       rate;
        logic [7:0]      dwell;
        logic [7:0]      qual;
        logic            choice_prev;
        logic            mode_prev;
        logic            mute_all;
        logic            loop_mute;
        logic            loop_reclk;
        logic            loop_data;
        logic            loop_oe;
        logic            reclock_in;
        logic            deser_run;
        logic [15:0]     dis;
        logic [4:0][15:0] anc;
        logic [5:0]      proc_en;
    } sis_core_state_t;

endpackage : sis_pkg

// ### rtl/sis_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for a group of asynchronous levels.
module sis_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst,
    // Levels in and out.
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s2;
        logic [W-1:0] s1;
    } sis_sync_state_t;

    sis_sync_state_t s_q;
    sis_sync_state_t s_d;

    // The first stage feeds only the second.
    always_comb begin
        s_d    = s_q;
        s_d.s1 = din;
        s_d.s2 = s_q.s1;
    end

    // Registers clear to zero on reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.s2;

endmodule : sis_sync

`default_nettype wire

// ### rtl/sis_hsp.sv
`timescale 1ns/1ps
`default_nettype none
`include "sis_defs.svh"

// Host serial port slave: 16-bit command, then 16-bit data, MSB first.
module sis_hsp (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // Synchronised port pins.
    input  wire logic        sclk_s,
    input  wire logic        cs_n_s,
    input  wire logic        sdi_s,
    output logic             sdo,
    // Register access.
    input  wire logic [15:0] rdata,
    output logic      [11:0] addr,
    output logic             wr,
    output logic      [15:0] wdata
);
    import sis_pkg::*;

    sis_hsp_state_t s_q;
    sis_hsp_state_t s_d;
    logic           rise;
    logic           fall;

    assign rise = sclk_s & ~s_q.sclk_prev;
    assign fall = ~sclk_s & s_q.sclk_prev;

    // Shift in on rising edges, shift read data out on falling edges.
    always_comb begin
        s_d           = s_q;
        s_d.wr        = 1'b0;
        s_d.ld        = 1'b0;
        s_d.sclk_prev = sclk_s;
        if (cs_n_s) begin
            s_d.cnt = 6'h00;
            s_d.sdo = 1'b0;
        end else begin
            if (rise && s_q.cnt != `SIS_HSP_FRAME_BITS) begin
                s_d.sh  = {s_q.sh[14:0], sdi_s};
                s_d.cnt = s_q.cnt + 6'h01;
                if (s_q.cnt == `SIS_HSP_CMD_BITS - 6'h01) begin
                    s_d.cmd = {s_q.sh[14:0], sdi_s};
                    s_d.ld  = 1'b1;
                end
                if (s_q.cnt == `SIS_HSP_FRAME_BITS - 6'h01 && !s_q.cmd[`SIS_HSP_RW_BIT]) begin
                    s_d.wr = 1'b1;
                end
            end
            if (s_q.ld) begin
                s_d.tx = rdata;
            end
            if (fall && s_q.cnt >= `SIS_HSP_CMD_BITS && s_q.cnt != `SIS_HSP_FRAME_BITS) begin
                s_d.sdo = s_q.tx[15];
                s_d.tx  = {s_q.tx[14:0], 1'b0};
            end
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign addr  = s_q.cmd[11:0];
    assign wr    = s_q.wr;
    assign wdata = s_q.sh;
    assign sdo   = s_q.sdo;

endmodule : sis_hsp

`default_nettype wire

// ### rtl/sis_input_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "sis_defs.svh"

module sis_input_select (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // Serial inputs and carrier flags.
    input  wire logic        serial_in_a,
    input  wire logic        serial_in_b,
    input  wire logic        carrier_ok_a_n,
    input  wire logic        carrier_ok_b_n,
    input  wire logic        input_choice,
    // Mode and slave configuration pins.
    input  wire logic        master_mode,
    input  wire logic        rate_hd,
    input  wire logic        rate_hd_1001,
    input  wire logic        reclock_pick_in,
    output logic             reclock_pick_out,
    output logic             reclock_pick_oe,
    // Reclocker side.
    input  wire logic        pll_lock,
    input  wire logic        reclk_data,
    output logic             reclock_in,
    output sis_pkg::sis_rate_t rate_sel,
    output logic             vco_centre,
    output logic             deser_run,
    // Status and outputs.
    output logic             locked,
    output logic             outputs_mute,
    input  wire logic        loop_enable,
    output logic             loop_data,
    output logic             loop_oe,
    output logic      [5:0]  proc_enable,
    output logic             hsync_cfg,
    // Host serial port.
    input  wire logic        hsp_sclk,
    input  wire logic        hsp_cs_n,
    input  wire logic        hsp_sdi,
    output logic             hsp_sdo
);
    import sis_pkg::*;

    sis_core_state_t s_q;
    sis_core_state_t s_d;
    sis_pins_t       pin_raw;
    sis_pins_t       p;
    logic [2:0]      hsp_s;
    logic [11:0]     h_addr;
    logic            h_wr;
    logic [15:0]     h_wdata;
    logic [15:0]     h_rdata;
    logic            sel_cd_n;
    logic            sel_ser;
    logic            restart;
    sis_rate_t       pin_rate;
    logic [11:0]     anc_idx;
    logic            loop_mute_chk;

    // Next rate in the master scan order.
    function automatic sis_rate_t sis_next_rate(input sis_rate_t r);
        case (r)
            SIS_RATE_SD:      sis_next_rate = SIS_RATE_HD;
            SIS_RATE_HD:      sis_next_rate = SIS_RATE_HD_1001;
            SIS_RATE_HD_1001: sis_next_rate = SIS_RATE_SD;
            default:          sis_next_rate = SIS_RATE_SD;
        endcase
    endfunction : sis_next_rate

    // Gather the asynchronous pins for synchronisation.
    always_comb begin
        pin_raw            = '0;
        pin_raw.choice     = input_choice;
        pin_raw.master     = master_mode;
        pin_raw.cd_a_n     = carrier_ok_a_n;
        pin_raw.cd_b_n     = carrier_ok_b_n;
        pin_raw.ser_a      = serial_in_a;
        pin_raw.ser_b      = serial_in_b;
        pin_raw.pll_lk     = pll_lock;
        pin_raw.rate_hd    = rate_hd;
        pin_raw.rate_1001  = rate_hd_1001;
        pin_raw.reclk_pick = reclock_pick_in;
        pin_raw.loop_en    = loop_enable;
        pin_raw.reclk_data = reclk_data;
    end

    sis_sync #(
        .W ($bits(sis_pins_t))
    ) u_pin_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (pin_raw),
        .dout (p)
    );

    sis_sync #(
        .W (3)
    ) u_hsp_sync (
        .clk  (clk),
        .rst  (rst),
        .din  ({hsp_sclk, hsp_cs_n, hsp_sdi}),
        .dout (hsp_s)
    );

    sis_hsp u_hsp (
        .clk    (clk),
        .rst    (rst),
        .sclk_s (hsp_s[2]),
        .cs_n_s (hsp_s[1]),
        .sdi_s  (hsp_s[0]),
        .sdo    (hsp_sdo),
        .rdata  (h_rdata),
        .addr   (h_addr),
        .wr     (h_wr),
        .wdata  (h_wdata)
    );

    // Selected input, selected carrier and restart detection.
    assign sel_ser  = p.choice ? p.ser_a : p.ser_b;
    assign sel_cd_n = p.choice ? p.cd_a_n : p.cd_b_n;
    assign restart  = (p.choice != s_q.choice_prev) || (p.master != s_q.mode_prev);
    assign anc_idx  = h_addr - `SIS_REG_ANC_BASE;
    assign loop_mute_chk = s_q.loop_mute;

    // Slave-mode rate taken from the configuration pins.
    always_comb begin
        if (!p.rate_hd) begin
            pin_rate = SIS_RATE_SD;
        end else if (p.rate_1001) begin
            pin_rate = SIS_RATE_HD_1001;
        end else begin
            pin_rate = SIS_RATE_HD;
        end
    end

    // Lock acquisition, output muting and host register writes.
    always_comb begin
        s_d             = s_q;
        s_d.choice_prev = p.choice;
        s_d.mode_prev   = p.master;
        case (s_q.st)
            SIS_IDLE: begin
                s_d.qual  = 8'h00;
                s_d.dwell = 8'h00;
                s_d.st    = SIS_SEEK;
            end
            SIS_SEEK: begin
                if (p.pll_lk) begin
                    if (s_q.qual == 8'(`SIS_LOCK_QUAL_CYC - 1)) begin
                        s_d.st = SIS_LOCKED;
                    end else begin
                        s_d.qual = s_q.qual + 8'h01;
                    end
                end else begin
                    s_d.qual = 8'h00;
                    if (s_q.dwell == 8'(`SIS_RATE_DWELL_CYC - 1)) begin
                        s_d.dwell = 8'h00;
                        s_d.rate  = sis_next_rate(s_q.rate);
                    end else begin
                        s_d.dwell = s_q.dwell + 8'h01;
                    end
                end
            end
            SIS_LOCKED: begin
                if (!p.pll_lk) begin
                    s_d.st    = SIS_SEEK;
                    s_d.qual  = 8'h00;
                    s_d.dwell = 8'h00;
                end
            end
            default: begin
                s_d.st = SIS_IDLE;
            end
        endcase
        // Slave mode follows the rate pins instead of scanning.
        if (!p.master) begin
            s_d.rate = pin_rate;
        end
        // Invalid carrier or a change of source or mode holds acquisition at rest.
        if (sel_cd_n || restart) begin
            s_d.st = SIS_IDLE;
        end
        s_d.mute_all   = sel_cd_n;
        s_d.loop_reclk = p.master ? (s_d.st == SIS_LOCKED) : p.reclk_pick;
        s_d.loop_mute  = sel_cd_n | (!p.master & p.reclk_pick & (s_d.st != SIS_LOCKED));
        s_d.loop_data  = s_d.loop_mute ? 1'b0 : (s_d.loop_reclk ? p.reclk_data : sel_ser);
        s_d.loop_oe    = p.loop_en;
        s_d.reclock_in = sel_ser;
        s_d.deser_run  = !sel_cd_n && (s_d.st != SIS_IDLE);
        // Host writes; reserved bits are dropped.
        if (h_wr) begin
            if (h_addr == `SIS_REG_PROC_DIS) begin
                s_d.dis = h_wdata & `SIS_DIS_MASK;
            end else if (h_addr >= `SIS_REG_ANC_BASE && h_addr <= `SIS_REG_ANC_LAST) begin
                s_d.anc[anc_idx[2:0]] = h_wdata;
            end
        end
        s_d.proc_en = ~s_d.dis[5:0];
    end

    // Host read data; unmapped offsets read zero.
    always_comb begin
        h_rdata = 16'h0000;
        if (h_addr == `SIS_REG_PROC_DIS) begin
            h_rdata = s_q.dis;
        end else if (h_addr >= `SIS_REG_ANC_BASE && h_addr <= `SIS_REG_ANC_LAST) begin
            h_rdata = s_q.anc[anc_idx[2:0]];
        end else if (h_addr == `SIS_REG_STATUS) begin
            h_rdata[`SIS_ST_CHOICE]     = p.choice;
            h_rdata[`SIS_ST_MASTER]     = p.master;
            h_rdata[`SIS_ST_CARRIER_N]  = sel_cd_n;
            h_rdata[`SIS_ST_LOCKED]     = (s_q.st == SIS_LOCKED);
            h_rdata[`SIS_ST_VCO_CTR]    = (s_q.st == SIS_IDLE);
            h_rdata[`SIS_ST_LOOP_MUTE]  = s_q.loop_mute;
            h_rdata[`SIS_ST_LOOP_RECLK] = s_q.loop_reclk;
            h_rdata[`SIS_ST_RATE_LO+:2] = s_q.rate;
        end
    end

    // State register; every processing function starts enabled.
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q      <= '0;
            s_q.st   <= SIS_IDLE;
            s_q.rate <= SIS_RATE_SD;
            s_q.dis  <= `SIS_DIS_RST;
            s_q.proc_en <= `SIS_PROC_EN_RST;
            s_q.anc  <= {5{`SIS_ANC_RST}};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs.
    assign locked           = (s_q.st == SIS_LOCKED);
    assign vco_centre       = (s_q.st == SIS_IDLE);
    assign outputs_mute     = s_q.mute_all;
    assign rate_sel         = s_q.rate;
    assign reclock_in       = s_q.reclock_in;
    assign deser_run        = s_q.deser_run;
    assign loop_data        = s_q.loop_data;
    assign loop_oe          = s_q.loop_oe;
    assign reclock_pick_out = s_q.loop_reclk;
    assign reclock_pick_oe  = p.master;
    assign proc_enable      = s_q.proc_en;
    assign hsync_cfg        = s_q.dis[`SIS_DIS_HCFG];

    AST_SEL_ROUTE: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> reclock_in == $past(sel_ser))
        else $error("Reclocker input does not follow the chosen serial input.");

    AST_CARRIER_LOCK: assert property (@(posedge clk) disable iff (rst)
        (p.choice ? p.cd_a_n : p.cd_b_n) |=> !locked && vco_centre)
        else $error("Lock held while the chosen carrier flag is high.");

    AST_INVALID_MUTE: assert property (@(posedge clk) disable iff (rst)
        sel_cd_n |=> outputs_mute && !deser_run)
        else $error("Outputs not muted on an invalid carrier.");

    AST_LOOP_MUTE: assert property (@(posedge clk) disable iff (rst)
        sel_cd_n |=> loop_mute_chk && !loop_data)
        else $error("Loop-through output not muted on an invalid carrier.");

    AST_LOOP_HIZ: assert property (@(posedge clk) disable iff (rst)
        !p.loop_en ##1 !p.loop_en |-> !loop_oe)
        else $error("Loop-through output driven while disabled.");

    AST_RESET_ENABLES: assert property (@(posedge clk)
        rst |=> proc_enable == 6'h3f && !hsync_cfg)
        else $error("Processing functions not all enabled after reset.");

    AST_RESTART: assert property (@(posedge clk) disable iff (rst)
        $changed(p.choice) || $changed(p.master) |=> !locked)
        else $error("Lock survived a change of source or mode.");

    AST_MASTER_SCAN: assert property (@(posedge clk) disable iff (rst)
        p.master && !restart && !sel_cd_n && s_q.st == SIS_SEEK && !p.pll_lk
        && s_q.dwell == 8'(`SIS_RATE_DWELL_CYC - 1) |=> rate_sel != $past(rate_sel))
        else $error("Master scan did not advance the rate.");

    AST_QUAL_LOCK: assert property (@(posedge clk) disable iff (rst)
        s_q.st == SIS_SEEK && p.pll_lk && !restart && !sel_cd_n
        && s_q.qual == 8'(`SIS_LOCK_QUAL_CYC - 1) |=> locked ##1 (locked || !$past(p.pll_lk) || vco_centre))
        else $error("Qualified PLL lock not reported.");

    AST_SLAVE_RATE: assert property (@(posedge clk) disable iff (rst)
        !p.master |=> rate_sel == $past(pin_rate))
        else $error("Slave rate does not follow the rate pins.");

endmodule : sis_input_select

`default_nettype wire

// ### bench/sis_board_model.sv
`timescale 1ns/1ps
`default_nettype none

// Board logic ahead of the receiver: drives the carrier flags and serial streams.
module sis_board_model (
    // Clock.
    input  wire logic clk,
    // Stimulus from the bench.
    input  wire logic single_mode,
    input  wire logic valid_a,
    input  wire logic valid_b,
    input  wire logic lvl_a,
    input  wire logic lvl_b,
    // Lines toward the receiver.
    output logic      serial_in_a,
    output logic      serial_in_b,
    output logic      carrier_ok_a_n,
    output logic      carrier_ok_b_n
);
    logic tog;

    // Everything starts with both inputs reported invalid.
    initial begin
        tog = 1'b0;
        serial_in_a = 1'b0;
        serial_in_b = 1'b0;
        carrier_ok_a_n = 1'b1;
        carrier_ok_b_n = 1'b1;
    end

    // Flags go low only for a valid stream; a dead input carries a pattern that changes every cycle.
    always @(posedge clk) begin
        tog <= ~tog;
        carrier_ok_a_n <= ~valid_a;
        carrier_ok_b_n <= ~valid_b | single_mode;
        serial_in_a <= valid_a ? lvl_a : tog;
        serial_in_b <= (valid_b && !single_mode) ? lvl_b : ~tog;
    end
endmodule : sis_board_model

`default_nettype wire

// ### bench/sis_input_select_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sis_defs.svh"

`define CHK_EQ(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", nm, e, g); end end

// Self-checking bench for the input selection and carrier front end.
module sis_input_select_tb_top;
    import sis_pkg::*;

    logic clk, rst, ser_a, ser_b, cd_a_n, cd_b_n, choice, master, r_hd, r_1001, pick_tb, pick_in;
    logic pick_out, pick_oe, pll_lock, reclk_data, reclock_in, vco_centre, deser_run, locked;
    logic outputs_mute, loop_enable, loop_data, loop_oe, hsync_cfg, sclk, cs_n, sdi, sdo;
    logic single, va, vb, la, lb, flag;
    logic [5:0] proc_enable;
    logic [15:0] w, r;
    logic [2:0] seen;
    sis_rate_t rate_sel;
    int err_count, samples_checked;
    const sis_rate_t rt[3] = '{SIS_RATE_SD, SIS_RATE_HD, SIS_RATE_HD_1001};

    // The shared pick pin carries the design's value whenever it drives.
    assign pick_in = pick_oe ? pick_out : pick_tb;

    // Clock at 40 MHz.
    always #12.5 clk = ~clk;

    sis_board_model u_board (.clk(clk), .single_mode(single), .valid_a(va), .valid_b(vb), .lvl_a(la), .lvl_b(lb),
        .serial_in_a(ser_a), .serial_in_b(ser_b), .carrier_ok_a_n(cd_a_n), .carrier_ok_b_n(cd_b_n));

    sis_input_select u_dut (.clk(clk), .rst(rst), .serial_in_a(ser_a), .serial_in_b(ser_b),
        .carrier_ok_a_n(cd_a_n), .carrier_ok_b_n(cd_b_n), .input_choice(choice), .master_mode(master),
        .rate_hd(r_hd), .rate_hd_1001(r_1001), .reclock_pick_in(pick_in), .reclock_pick_out(pick_out),
        .reclock_pick_oe(pick_oe), .pll_lock(pll_lock), .reclk_data(reclk_data), .reclock_in(reclock_in),
        .rate_sel(rate_sel), .vco_centre(vco_centre), .deser_run(deser_run), .locked(locked),
        .outputs_mute(outputs_mute), .loop_enable(loop_enable), .loop_data(loop_data), .loop_oe(loop_oe),
        .proc_enable(proc_enable), .hsync_cfg(hsync_cfg), .hsp_sclk(sclk), .hsp_cs_n(cs_n), .hsp_sdi(sdi),
        .hsp_sdo(sdo));

    // Prints the verdict and ends the run.
    task automatic results();
        if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // One host frame: command then data, MSB first; read data sampled just before each falling clock.
    task automatic hsp(input logic [15:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
        logic [31:0] fr;
        fr = {cmd, wd};
        rd = 16'h0000;
        cs_n <= 1'b0;
        tick(5);
        for (int i = 31; i >= 0; i--) begin
            sclk <= 1'b0;
            sdi <= fr[i];
            tick(5);
            sclk <= 1'b1;
            tick(5);
            if (i < 16) rd[i] = sdo;
        end
        tick(6);
        cs_n <= 1'b1;
        tick(6);
    endtask : hsp

    // Waits a bounded time for the lock output to reach a level.
    task automatic wait_lock(input logic want, input int lim);
        for (int k = 0; k < lim && locked !== want; k++) tick(1);
        if (locked !== want) begin
            err_count++;
            results();
        end
    endtask : wait_lock

    // Main sequence.
    initial begin
        void'($urandom(50));
        {clk, choice, r_hd, r_1001, pick_tb, pll_lock, reclk_data, sdi, single, la, lb} = '0;
        {rst, master, loop_enable, sclk, cs_n, va, vb} = '1;
        err_count = 0;
        samples_checked = 0;
        tick(16);
        #2;
        `CHK_EQ("proc_enable", 6'h3f, proc_enable)
        `CHK_EQ("vco_centre", 1'b1, vco_centre)
        @(posedge clk);
        rst <= 1'b0;
        master <= 1'b0;
        tick(4);
        // Random selection sweep in slave mode with a buffered loop-through.
        for (int i = 0; i < 24; i++) begin
            @(posedge clk);
            {choice, va, vb, la, lb} <= {(i != 0) && 1'($urandom), 4'($urandom)};
            single <= (i == 0) || ($urandom % 4 == 0);
            tick(5);
            #2;
            flag = choice ? ~va : (~vb | single);
            `CHK_EQ("outputs_mute", flag, outputs_mute)
            if (!flag) `CHK_EQ("reclock_in", choice ? la : lb, reclock_in)
            `CHK_EQ("loop_data", flag ? 1'b0 : (choice ? la : lb), loop_data)
            if (flag) `CHK_EQ("locked", 1'b0, locked)
        end
        // Slave rate pins.
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            r_hd <= (i != 0);
            r_1001 <= (i == 2);
            tick(5);
            #2;
            `CHK_EQ("rate_sel", rt[i], rate_sel)
        end
        // Slave, reclocked loop-through picked: muted until locked, then reclocked data.
        @(posedge clk);
        {single, choice, va, la, pll_lock, pick_tb} <= 6'b011111;
        tick(5);
        #2;
        `CHK_EQ("loop_data", 1'b0, loop_data)
        `CHK_EQ("deser_run", 1'b1, deser_run)
        wait_lock(1'b1, 60);
        reclk_data <= 1'b1;
        loop_enable <= 1'b0;
        tick(5);
        #2;
        `CHK_EQ("loop_data", 1'b1, loop_data)
        `CHK_EQ("loop_oe", 1'b0, loop_oe)
        @(posedge clk);
        loop_enable <= 1'b1;
        master <= 1'b1;
        wait_lock(1'b0, 6);
        wait_lock(1'b1, 60);
        #2;
        `CHK_EQ("pick_out", 2'b11, {pick_oe, pick_out})
        `CHK_EQ("loop_oe", 1'b1, loop_oe)
        @(posedge clk);
        {choice, vb} <= 2'b01;
        wait_lock(1'b0, 6);
        wait_lock(1'b1, 60);
        vb <= 1'b0;
        wait_lock(1'b0, 6);
        tick(3);
        #2;
        `CHK_EQ("invalid", 3'b110, {vco_centre, outputs_mute, loop_data})
        // Master scan without lock visits every line rate.
        @(posedge clk);
        {vb, pll_lock} <= 2'b10;
        seen = '0;
        repeat (700) begin
            tick(1);
            seen[rate_sel] = 1'b1;
        end
        `CHK_EQ("rates_seen", 3'b111, seen)
        // Status while scanning: input B chosen, master, carrier valid, not locked.
        hsp({4'h8, `SIS_REG_STATUS}, 16'h0000, r);
        `CHK_EQ("status", 7'h02, r[6:0])
        // Host register accesses.
        hsp({4'h8, `SIS_REG_PROC_DIS}, 16'h0000, r);
        `CHK_EQ("dis_reset", 16'h0000, r)
        for (int i = 0; i < 4; i++) begin
            w = (i == 0) ? 16'hffff : 16'($urandom);
            hsp({4'h0, `SIS_REG_PROC_DIS}, w, r);
            hsp({4'h8, `SIS_REG_PROC_DIS}, 16'h0000, r);
            `CHK_EQ("dis_reg", w & 16'h013f, r)
            `CHK_EQ("proc_enable", ~w[5:0], proc_enable)
            `CHK_EQ("hsync_cfg", w[8], hsync_cfg)
        end
        hsp({4'h0, 12'h00a}, 16'h0000, r);
        hsp({4'h8, `SIS_REG_PROC_DIS}, 16'h0000, r);
        `CHK_EQ("dis_keep", w & 16'h013f, r)
        for (int a = 5; a < 10; a++) begin
            w = 16'($urandom);
            hsp({4'h0, 12'(a)}, w, r);
            hsp({4'h8, 12'(a)}, 16'h0000, r);
            `CHK_EQ("anc_reg", w, r)
        end
        results();
    end
endmodule : sis_input_select_tb_top

`default_nettype wire
